// ### hw/fthcsr_pkg.sv
package fthcsr_pkg;

  // Core clock rate.
  localparam int CLK_HZ = 250_000_000;

  // Bus address width; each register index sits at byte address four times the index.
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_CFG1 = 8'h00;
  localparam logic [7:0] IDX_CFG2 = 8'h01;
  localparam logic [7:0] IDX_STAT1 = 8'h02;
  localparam logic [7:0] IDX_STAT2 = 8'h03;
  localparam logic [7:0] IDX_FRAC = 8'h06;
  localparam logic [7:0] IDX_TLIM1 = 8'h10;
  localparam logic [7:0] IDX_TLIM2 = 8'h11;
  localparam logic [7:0] IDX_FANCH1 = 8'h20;

  // Reset values.
  localparam logic [7:0] CFG1_RST = 8'h90;
  localparam logic [7:0] CFG2_RST = 8'h7F;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] FRAC_RST = 8'h00;
  localparam logic [7:0] TLIM_RST = 8'hFF;
  localparam logic [7:0] FANCH1_RST = 8'h5D;

  // Field positions.
  localparam int CFG1_MON = 0;
  localparam int CFG2_PWM_LSB = 0;
  localparam int CFG2_TACH_LSB = 2;
  localparam int CFG2_LOC_IE = 4;
  localparam int CFG2_REM_LSB = 5;
  localparam int CFG2_SRST = 7;
  localparam int ST_ALARM = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_HIGH = 2;
  localparam int ST_LOW = 3;
  localparam int ST_OT = 4;
  localparam int ST_DIODE = 5;
  localparam int ST1_LOC_HIGH = 6;
  localparam int ST1_LOC_LOW = 7;
  localparam int ST2_LOC_OT = 6;
  localparam int ST2_LINE = 7;
  localparam int FR_R1_LSB = 0;
  localparam int FR_R2_LSB = 3;
  localparam int FR_LOC_LSB = 6;
  localparam int FC_SPIN_LSB = 0;
  localparam int FC_FREQ_LSB = 3;
  localparam int FC_RANGE_LSB = 6;

  // Status bits that a read clears; the diode error bit is excluded.
  localparam logic [7:0] ST_CLR_MASK = 8'hDF;

  // Spin-up time in ms, drive frequency in hundredths of Hz, speed divisor N.
  localparam logic [13:0] SPIN_MS_TBL [8] = '{14'd200, 14'd400, 14'd600, 14'd800,
                                              14'd1000, 14'd2000, 14'd4000, 14'd8000};
  localparam logic [13:0] FREQ_CHZ_TBL [8] = '{14'd1170, 14'd1560, 14'd2340, 14'd3125,
                                               14'd3750, 14'd4690, 14'd6250, 14'd9350};
  localparam logic [3:0] SPEED_DIV_TBL [4] = '{4'h1, 4'h2, 4'h4, 4'h8};

  // Results of one monitoring cycle from the measurement engine.
  typedef struct packed {
    logic tick;
    logic [1:0] alarm;
    logic [1:0][7:0] tach_count;
    logic [1:0] rem_high;
    logic [1:0] rem_low;
    logic [1:0] rem_ot;
    logic loc_high;
    logic loc_low;
    logic loc_ot;
    logic [7:0] frac;
  } fthcsr_mon_type;

  // Decoded fan 1 characteristics.
  typedef struct packed {
    logic [13:0] spin_ms;
    logic [13:0] freq_chz;
    logic [3:0] speed_div;
  } fthcsr_fan_type;

endpackage : fthcsr_pkg

// ### hw/fthcsr_regs.sv
// Function
// (RULE1) Fan drive outputs pass only while config-2 bits 0 and 1 are one.
// (RULE2) Speed-sense inputs pass only while config-2 bits 2 and 3 are one.
// (RULE3) Config-2 bits 4, 5, 6 gate alerts of local, remote 1, remote 2.
// (RULE4) Remote alert enables come up set unless the power-up diode check fails.
// (RULE5) Writing one to config-2 bit 7 resets the block; bit reads zero.
// (RULE6) Config-2 reads 7F after reset, minus enables of faulty diodes.
// (RULE7) Alarm-speed flag sets on alarm; after a read, not again while alarm persists.
// (RULE8) Fan fault flag sets when a fan stalls or runs under speed.
// (RULE9) Remote high and low flags set, and set again while condition persists.
// (RULE10) Remote overtemperature flag sets on excess and clears on status read.
// (RULE11) Diode error flag set only by power-up check; reads do not clear it.
// (RULE12) Status-1 bit 7 sets while local temperature is below its low limit.
// (RULE13) Status-2 bit 6 sets on local overtemperature, clears on status read.
// (RULE14) Status-2 bit 7 sets when others pull the overtemp line low.
// (RULE15) Both status registers read zero after reset except diode errors.
// (RULE16) Fraction register: remote 1 in 2:0, remote 2 in 5:3, local 7:6.
// (RULE17) Fan 1 spin-up code selects 200 ms up to 8 s, default 2 s.
// (RULE18) Fan 1 frequency code selects 11.7 Hz up to 93.5 Hz.
// (RULE19) Speed range code selects divisor 1, 2, 4 or 8.
// (RULE20) Fan 1 characteristics register resets to 5D.
// (RULE21) Monitoring cycles update flags only while config-1 bit 0 is one.
// (RULE22) Fan is slow when its pulse count exceeds its tach limit, reset FF.
// (RULE23) Status-1 bit 6 sets on local high limit, again while it persists.
// (RULE24) Read-clear flags stay until read; an event during the read wins.
`timescale 1ns/1ps

module fthcsr_regs
  import fthcsr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire fthcsr_mon_type mon,
  input wire logic diode_check_done,
  input wire logic [1:0] diode_fault,
  input wire logic [1:0] pwm_drive,
  output logic [1:0] fan_pwm,
  input wire logic [1:0] tach_pin,
  output logic [1:0] tach_out,
  input wire logic overtemp_line_i,
  output logic overtemp_line_o,
  output logic overtemp_line_oe,
  output logic monitor_en,
  output logic soft_reset,
  output logic alert,
  output fthcsr_fan_type fan1_cfg
);

  typedef struct packed {
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic [1:0][7:0] stat;
    logic [7:0] frac;
    logic [1:0][7:0] tlim;
    logic [7:0] fanch1;
    logic [1:0] alarm_blk;
    logic diode_done;
    logic srst;
    logic [7:0] rdata;
    logic slverr;
    logic line_s1;
    logic line_s2;
    logic [1:0] tach_s1;
    logic [1:0] tach_s2;
    logic line_drv;
    logic [2:0] drv_hist;
    logic [1:0] fan_pwm;
    logic [1:0] tach_out;
    logic alert;
    fthcsr_fan_type fan1;
  } fthcsr_state_type;

  fthcsr_state_type st;
  fthcsr_state_type next_st;
  logic [7:0] idx;
  logic hit;
  logic [7:0] rd_val;
  logic rd_acc;
  logic wr_acc;
  logic [1:0] rd_st;
  logic mtick;
  logic line_low;
  logic [1:0] dset;
  logic [1:0][7:0] set_v;
  logic [1:0][7:0] clr_v;

  // Address decode; misaligned addresses count as unmapped.
  always_comb begin
    idx = paddr[ADDR_W-1:2];
    hit = 1'b0;
    rd_val = 8'h00;
    if (paddr[1:0] == 2'b00) begin
      hit = 1'b1;
      case (idx)
        IDX_CFG1: rd_val = st.cfg1;
        IDX_CFG2: rd_val = st.cfg2;
        IDX_STAT1: rd_val = st.stat[0];
        IDX_STAT2: rd_val = st.stat[1];
        IDX_FRAC: rd_val = st.frac; // [RULE16]
        IDX_TLIM1: rd_val = st.tlim[0];
        IDX_TLIM2: rd_val = st.tlim[1];
        IDX_FANCH1: rd_val = st.fanch1;
        default: hit = 1'b0;
      endcase
    end
  end

  // Event terms for this cycle.
  always_comb begin
    rd_acc = psel & penable & ~pwrite;
    wr_acc = psel & penable & pwrite & pstrb[0] & hit;
    rd_st[0] = rd_acc & hit & (idx == IDX_STAT1);
    rd_st[1] = rd_acc & hit & (idx == IDX_STAT2);
    mtick = mon.tick & st.cfg1[CFG1_MON]; // [RULE21]
    // The line is only sensed after our own drive has been off long enough to
    // flush the synchroniser, so our own pull never reads as someone else's.
    line_low = ~st.line_s2 & ~st.line_drv & (st.drv_hist == 3'h0); // [RULE14]
    dset = (diode_check_done & ~st.diode_done) ? diode_fault : 2'b00; // [RULE11]
    set_v = '0;
    for (int i = 0; i < 2; i++) begin
      set_v[i][ST_ALARM] = mtick & mon.alarm[i] & ~st.alarm_blk[i]; // [RULE7]
      set_v[i][ST_FAULT] = mtick & st.cfg2[CFG2_TACH_LSB+i]
                           & (mon.tach_count[i] > st.tlim[i]); // [RULE8] [RULE22]
      set_v[i][ST_HIGH] = mtick & mon.rem_high[i]; // [RULE9]
      set_v[i][ST_LOW] = mtick & mon.rem_low[i]; // [RULE9]
      set_v[i][ST_OT] = mtick & mon.rem_ot[i]; // [RULE10]
      set_v[i][ST_DIODE] = dset[i]; // [RULE11]
      // Only bits that this read returned are cleared, so a flag that sets
      // between the setup and access edges is kept for the next read.
      clr_v[i] = rd_st[i] ? (st.rdata & ST_CLR_MASK) : 8'h00; // [RULE24]
    end
    set_v[0][ST1_LOC_HIGH] = mtick & mon.loc_high; // [RULE23]
    set_v[0][ST1_LOC_LOW] = mtick & mon.loc_low; // [RULE12]
    set_v[1][ST2_LOC_OT] = mtick & mon.loc_ot; // [RULE13]
    set_v[1][ST2_LINE] = line_low; // [RULE14]
  end

  // Next-state logic for the whole block.
  always_comb begin
    next_st = st;
    // Pin synchronisers; only the second stage is read by logic.
    next_st.line_s1 = overtemp_line_i;
    next_st.line_s2 = st.line_s1;
    next_st.tach_s1 = tach_pin;
    next_st.tach_s2 = st.tach_s1;
    next_st.line_drv = st.cfg1[CFG1_MON] & (mon.loc_ot | (|mon.rem_ot));
    next_st.drv_hist = {st.drv_hist[1:0], st.line_drv};
    for (int i = 0; i < 2; i++) begin
      next_st.fan_pwm[i] = pwm_drive[i] & st.cfg2[CFG2_PWM_LSB+i]; // [RULE1]
      next_st.tach_out[i] = st.tach_s2[i] & st.cfg2[CFG2_TACH_LSB+i]; // [RULE2]
      // Clear first, then set, so an event during the read survives it.
      next_st.stat[i] = (st.stat[i] & ~clr_v[i]) | set_v[i]; // [RULE24]
      // A read during alarm blocks the flag until the alarm goes away.
      if (rd_st[i] & mon.alarm[i]) begin
        next_st.alarm_blk[i] = 1'b1; // [RULE7]
      end else if (~mon.alarm[i]) begin
        next_st.alarm_blk[i] = 1'b0;
      end
    end
    if (diode_check_done) begin
      next_st.diode_done = 1'b1;
    end
    if (mtick) begin
      next_st.frac = mon.frac; // [RULE16]
    end
    // Alert is one cycle behind the flags; a channel counts only if enabled.
    next_st.alert = (st.cfg2[CFG2_LOC_IE] & (st.stat[0][ST1_LOC_HIGH] | st.stat[0][ST1_LOC_LOW]
                     | st.stat[1][ST2_LOC_OT]))
                  | (st.cfg2[CFG2_REM_LSB] & (|st.stat[0][ST_OT:ST_HIGH]))
                  | (st.cfg2[CFG2_REM_LSB+1] & (|st.stat[1][ST_OT:ST_HIGH])); // [RULE3]
    next_st.fan1.spin_ms = SPIN_MS_TBL[st.fanch1[FC_SPIN_LSB+:3]]; // [RULE17]
    next_st.fan1.freq_chz = FREQ_CHZ_TBL[st.fanch1[FC_FREQ_LSB+:3]]; // [RULE18]
    next_st.fan1.speed_div = SPEED_DIV_TBL[st.fanch1[FC_RANGE_LSB+:2]]; // [RULE19]
    // Setup phase captures read data and the error answer.
    if (psel & ~penable) begin
      next_st.slverr = ~hit;
      next_st.rdata = pwrite ? 8'h00 : rd_val;
    end
    if (wr_acc) begin
      case (idx)
        IDX_CFG1: next_st.cfg1 = pwdata[7:0];
        IDX_CFG2: begin
          next_st.cfg2 = {1'b0, pwdata[6:0]};
          next_st.srst = pwdata[CFG2_SRST]; // [RULE5]
        end
        IDX_TLIM1: next_st.tlim[0] = pwdata[7:0];
        IDX_TLIM2: next_st.tlim[1] = pwdata[7:0];
        IDX_FANCH1: next_st.fanch1 = pwdata[7:0];
        default: next_st.cfg1 = st.cfg1;
      endcase
    end
    // A diode result overrides a write in the same cycle, since the check
    // never runs again and its outcome must not be lost.
    for (int i = 0; i < 2; i++) begin
      if (dset[i]) begin
        next_st.cfg2[CFG2_REM_LSB+i] = 1'b0; // [RULE4]
      end
    end
    // Soft reset lasts one cycle and spares the power-up diode results, since
    // that check never runs again; the bit therefore clears itself.
    if (st.srst) begin
      next_st.cfg1 = CFG1_RST;
      next_st.cfg2 = CFG2_RST & ~{1'b0, st.stat[1][ST_DIODE], st.stat[0][ST_DIODE], 5'h00}; // [RULE5] [RULE6]
      for (int i = 0; i < 2; i++) begin
        next_st.stat[i] = STAT_RST | (st.stat[i] & ~ST_CLR_MASK); // [RULE15]
        next_st.tlim[i] = TLIM_RST; // [RULE22]
      end
      next_st.frac = FRAC_RST;
      next_st.fanch1 = FANCH1_RST; // [RULE20]
      next_st.alarm_blk = 2'b00;
      next_st.srst = 1'b0;
      next_st.fan_pwm = 2'b00;
      next_st.tach_out = 2'b00;
      next_st.alert = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st.cfg1 <= CFG1_RST;
      st.cfg2 <= CFG2_RST; // [RULE6]
      st.stat <= {STAT_RST, STAT_RST}; // [RULE15]
      st.frac <= FRAC_RST;
      st.tlim <= {TLIM_RST, TLIM_RST}; // [RULE22]
      st.fanch1 <= FANCH1_RST; // [RULE20]
      st.alarm_blk <= 2'b00;
      st.diode_done <= 1'b0;
      st.srst <= 1'b0;
      st.rdata <= 8'h00;
      st.slverr <= 1'b0;
      st.line_s1 <= 1'b1;
      st.line_s2 <= 1'b1;
      st.tach_s1 <= 2'b00;
      st.tach_s2 <= 2'b00;
      st.line_drv <= 1'b0;
      st.drv_hist <= 3'h0;
      st.fan_pwm <= 2'b00;
      st.tach_out <= 2'b00;
      st.alert <= 1'b0;
      st.fan1 <= '{spin_ms: SPIN_MS_TBL[5], freq_chz: FREQ_CHZ_TBL[3], speed_div: SPEED_DIV_TBL[1]};
    end else begin
      st <= next_st;
    end
  end

  // Outputs; zero-wait slave, so pready is held high.
  assign prdata = {24'h000000, st.rdata};
  assign pready = 1'b1;
  assign pslverr = st.slverr;
  assign fan_pwm = st.fan_pwm;
  assign tach_out = st.tach_out;
  assign overtemp_line_o = 1'b0;
  assign overtemp_line_oe = st.line_drv;
  assign monitor_en = st.cfg1[CFG1_MON];
  assign soft_reset = st.srst;
  assign alert = st.alert;
  assign fan1_cfg = st.fan1;

  // Checks on the register behaviour.
  a_pwm_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
    st.fan_pwm[0] |-> $past(st.cfg2[0])) // [RULE1]
    else $error("Fan 1 drive active while disabled.");

  a_tach_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
    st.tach_out[1] |-> $past(st.cfg2[3])) // [RULE2]
    else $error("Tach 2 passed while disabled.");

  a_alert_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!st.cfg2[CFG2_REM_LSB] && !st.cfg2[CFG2_REM_LSB+1] && st.stat[0][7:6] == 2'b00
    && !st.stat[1][ST2_LOC_OT]) |=> !st.alert) // [RULE3]
    else $error("Alert raised by a disabled channel.");

  a_diode_enable: assert property (@(posedge core_clk) disable iff (!rst_b)
    (diode_check_done && !st.diode_done && diode_fault[1] && !st.srst)
    |=> !st.cfg2[6] && st.stat[1][ST_DIODE]) // [RULE4]
    else $error("Diode fault did not clear remote enable.");

  a_soft_reset: assert property (@(posedge core_clk) disable iff (!rst_b)
    st.srst |=> !st.srst && st.cfg1 == CFG1_RST && st.fanch1 == FANCH1_RST
    && st.cfg2[4:0] == 5'h1F && !st.cfg2[7]) // [RULE5] [RULE6] [RULE20]
    else $error("Soft reset did not restore defaults.");

  a_alarm_block: assert property (@(posedge core_clk) disable iff (!rst_b)
    (st.alarm_blk[0] && mon.alarm[0] && !st.stat[0][0]) |=> !st.stat[0][0]) // [RULE7]
    else $error("Alarm flag reasserted after read.");

  a_fault_set: assert property (@(posedge core_clk) disable iff (!rst_b)
    (mtick && st.cfg2[2] && mon.tach_count[0] > st.tlim[0] && !st.srst)
    |=> st.stat[0][ST_FAULT]) // [RULE8] [RULE22]
    else $error("Slow fan 1 not flagged.");

  a_high_persist: assert property (@(posedge core_clk) disable iff (!rst_b)
    (rd_st[0] && mtick && mon.rem_high[0] && !st.srst) |=> st.stat[0][ST_HIGH]) // [RULE9] [RULE24]
    else $error("High flag lost during read.");

  a_ot_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
    (rd_st[1] && st.rdata[ST2_LOC_OT] && !set_v[1][ST2_LOC_OT])
    |=> !st.stat[1][ST2_LOC_OT]) // [RULE13]
    else $error("Overtemperature flag survived read.");

  a_rem_ot_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
    (rd_st[1] && st.rdata[ST_OT] && !set_v[1][ST_OT])
    |=> !st.stat[1][ST_OT]) // [RULE10]
    else $error("Remote overtemperature flag survived read.");

  a_diode_sticky: assert property (@(posedge core_clk) disable iff (!rst_b)
    st.stat[1][ST_DIODE] |=> st.stat[1][ST_DIODE]) // [RULE11]
    else $error("Diode error flag cleared.");

  a_line_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
    (line_low && !st.srst) |=> st.stat[1][ST2_LINE]) // [RULE14]
    else $error("External overtemp pull not flagged.");

  a_monitor_off: assert property (@(posedge core_clk) disable iff (!rst_b)
    !st.cfg1[CFG1_MON] |=> !$rose(st.stat[0][ST1_LOC_LOW]) && !$rose(st.stat[0][ST1_LOC_HIGH])) // [RULE12] [RULE21] [RULE23]
    else $error("Flag set while monitoring off.");

  a_fan_decode: assert property (@(posedge core_clk) disable iff (!rst_b)
    (st.fanch1 == FANCH1_RST) [*2] |-> st.fan1.spin_ms == 14'd2000 && st.fan1.speed_div == 4'h2
    && st.fan1.freq_chz == 14'd3125) // [RULE17] [RULE18] [RULE19]
    else $error("Fan 1 characteristics decoded wrongly.");

  a_frac_capture: assert property (@(posedge core_clk) disable iff (!rst_b)
    (mtick && !st.srst) |=> st.frac == $past(mon.frac)) // [RULE16]
    else $error("Fraction bits not captured.");

  c_soft_reset: cover property (@(posedge core_clk) disable iff (!rst_b) st.srst);
  c_read_clear: cover property (@(posedge core_clk) disable iff (!rst_b)
    rd_st[0] && st.stat[0][ST_OT]);
  c_alarm_block: cover property (@(posedge core_clk) disable iff (!rst_b)
    st.alarm_blk[0] && mtick && mon.alarm[0]);
  c_line_pull: cover property (@(posedge core_clk) disable iff (!rst_b) line_low);
  c_read_set: cover property (@(posedge core_clk) disable iff (!rst_b)
    rd_st[0] && mtick);

endmodule : fthcsr_regs

// ### verification/fthcsr_far_model.sv
`timescale 1ns/1ps

module fthcsr_far_model
  import fthcsr_pkg::*;
#(
  parameter logic [1:0] FAULTY = 2'b10
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ext_pull,
  input wire logic overtemp_line_o,
  input wire logic overtemp_line_oe,
  output logic [1:0] pwm_drive,
  output logic [1:0] tach_pin,
  output logic overtemp_line_i,
  output logic diode_check_done,
  output logic [1:0] diode_fault
);
  logic [3:0] cnt;
  logic seen;

  // Free count that paces the fans and the one-time diode check.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 4'h0;
      seen <= 1'b0;
    end else begin
      cnt <= cnt + 4'h1;
      seen <= seen | diode_check_done;
    end
  end

  // Each channel toggles at its own rate so a swapped channel shows up.
  assign pwm_drive = {cnt[1], cnt[0]};
  assign tach_pin = {cnt[3], cnt[2]};
  // The check reports once after reset; outside it the fault lines carry junk.
  assign diode_check_done = rst_b & ~seen & (cnt == 4'h2);
  assign diode_fault = diode_check_done ? FAULTY : ~FAULTY;
  // The line has a pull-up, so it is low while any party pulls it.
  assign overtemp_line_i = ~((overtemp_line_oe & ~overtemp_line_o) | ext_pull);

endmodule : fthcsr_far_model

// ### verification/fthcsr_regs_tb_top.sv
`timescale 1ns/1ps

module fthcsr_regs_tb_top
  import fthcsr_pkg::*;
;
  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] a;
    logic [7:0] d;
    logic [7:0] e;
    logic err;
  } fthcsr_row_type;

  localparam logic [ADDR_W-1:0] A_CFG1 = {IDX_CFG1, 2'b00};
  localparam logic [ADDR_W-1:0] A_CFG2 = {IDX_CFG2, 2'b00};
  localparam logic [ADDR_W-1:0] A_ST1 = {IDX_STAT1, 2'b00};
  localparam logic [ADDR_W-1:0] A_ST2 = {IDX_STAT2, 2'b00};
  localparam logic [ADDR_W-1:0] A_FRAC = {IDX_FRAC, 2'b00};
  localparam logic [ADDR_W-1:0] A_TL1 = {IDX_TLIM1, 2'b00};
  localparam logic [ADDR_W-1:0] A_FAN1 = {IDX_FANCH1, 2'b00};
  localparam logic [13:0] SP [8] = '{14'd200, 14'd400, 14'd600, 14'd800,
                                     14'd1000, 14'd2000, 14'd4000, 14'd8000};
  localparam logic [13:0] FQ [8] = '{14'd1170, 14'd1560, 14'd2340, 14'd3125,
                                     14'd3750, 14'd4690, 14'd6250, 14'd9350};
  localparam logic [3:0] DV [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
  // Reset values, a write to a read-only place, an unmapped address and a limit write read back.
  localparam fthcsr_row_type ROWS [12] = '{
    '{1'b0, A_CFG1, 8'h00, 8'h90, 1'b0},
    '{1'b0, A_CFG2, 8'h00, 8'h3F, 1'b0}, // Remote 2 diode is faulty.
    '{1'b0, A_ST1, 8'h00, 8'h00, 1'b0}, // Clean status.
    '{1'b0, A_ST2, 8'h00, 8'h20, 1'b0}, // Diode error only.
    '{1'b0, A_FRAC, 8'h00, 8'h00, 1'b0},
    '{1'b0, A_FAN1, 8'h00, 8'h5D, 1'b0}, // Fan defaults.
    '{1'b0, A_TL1, 8'h00, 8'hFF, 1'b0}, // Limit default.
    '{1'b1, A_ST1, 8'hFF, 8'h00, 1'b0},
    '{1'b0, A_ST1, 8'h00, 8'h00, 1'b0},
    '{1'b0, 10'h3FC, 8'h00, 8'h00, 1'b1},
    '{1'b1, A_TL1, 8'h10, 8'h00, 1'b0},
    '{1'b0, A_TL1, 8'h00, 8'h10, 1'b0}};

  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  fthcsr_mon_type mon = '0;
  logic diode_check_done;
  logic [1:0] diode_fault;
  logic [1:0] pwm_drive;
  logic [1:0] fan_pwm;
  logic [1:0] tach_pin;
  logic [1:0] tach_out;
  logic overtemp_line_i;
  logic overtemp_line_o;
  logic overtemp_line_oe;
  logic monitor_en;
  logic soft_reset;
  logic alert;
  fthcsr_fan_type fan1_cfg;
  logic ext_pull = 1'b0;
  logic [31:0] rdat;
  logic rerr;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  fthcsr_regs fthcsr_regs_inst (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mon(mon),
    .diode_check_done(diode_check_done), .diode_fault(diode_fault), .pwm_drive(pwm_drive),
    .fan_pwm(fan_pwm), .tach_pin(tach_pin), .tach_out(tach_out),
    .overtemp_line_i(overtemp_line_i), .overtemp_line_o(overtemp_line_o),
    .overtemp_line_oe(overtemp_line_oe), .monitor_en(monitor_en), .soft_reset(soft_reset),
    .alert(alert), .fan1_cfg(fan1_cfg));

  fthcsr_far_model fthcsr_far_model_inst (.core_clk(core_clk), .rst_b(rst_b),
    .ext_pull(ext_pull), .overtemp_line_o(overtemp_line_o),
    .overtemp_line_oe(overtemp_line_oe), .pwm_drive(pwm_drive), .tach_pin(tach_pin),
    .overtemp_line_i(overtemp_line_i), .diode_check_done(diode_check_done),
    .diode_fault(diode_fault));

  // Free-running core clock.
  always #2 core_clk = ~core_clk;

  task automatic summarize();
    if (n_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  // The whole run needs well under a thousand cycles, so this only catches a hang.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors = n_errors + 1;
      summarize();
    end
  end

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One transfer; the request is held until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'h1;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk({rerr, rdat}, {9'h000, 24'h0, e});
  endtask : rd

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr

  // One monitoring pulse; the levels stay as given afterwards, as a real engine holds them.
  task automatic tick(input fthcsr_mon_type m);
    m.tick = 1'b1;
    @(posedge core_clk);
    mon <= m;
    m.tick = 1'b0;
    @(posedge core_clk);
    mon <= m;
  endtask : tick

  // Table first, then the hand-written event cases.
  initial begin
    fthcsr_mon_type m;
    logic [1:0] e2;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    foreach (ROWS[i]) begin
      apb(ROWS[i].wr, ROWS[i].a, {24'h0, ROWS[i].d});
      if (!ROWS[i].wr) chk({rerr, ROWS[i].err ? 32'h0 : rdat}, {ROWS[i].err, 24'h0, ROWS[i].e}); // Row.
    end
    wr(A_CFG1, 8'h91);
    #1 chk({32'h0, monitor_en}, 33'h1); // Monitoring on.
    m = '0;
    m.rem_high[0] = 1'b1;
    m.loc_low = 1'b1;
    m.frac = 8'hB5;
    tick(m);
    repeat (2) @(posedge core_clk);
    #1 chk({32'h0, alert}, 33'h1); // Enabled channels alert.
    rd(A_ST1, 8'h84); // Remote high and local low.
    rd(A_FRAC, 8'hB5); // Fractions in place.
    // A tick lands on the access edge of a read that returned nothing.
    fork
      rd(A_ST1, 8'h00); // Read taken before the event.
      begin
        @(posedge core_clk);
        tick(m);
      end
    join
    rd(A_ST1, 8'h84); // The event during the read survives.
    tick(m);
    rd(A_ST1, 8'h84); // Set again while it persists.
    tick('0);
    rd(A_ST1, 8'h00); // Cleared by the read.
    m = '0;
    m.alarm[0] = 1'b1;
    tick(m);
    rd(A_ST1, 8'h01); // Alarm speed seen.
    tick(m);
    rd(A_ST1, 8'h00); // Not set again after the read.
    tick('0);
    tick(m);
    rd(A_ST1, 8'h01); // A new alarm sets it.
    m = '0;
    m.tach_count[0] = 8'h11;
    tick(m);
    rd(A_ST1, 8'h02); // Count above limit is a fault.
    m.tach_count[0] = 8'h10;
    tick(m);
    rd(A_ST1, 8'h00); // Equal count is no fault.
    m = '0;
    m.rem_ot[1] = 1'b1;
    m.loc_ot = 1'b1;
    tick(m);
    #1 chk({31'h0, overtemp_line_oe, overtemp_line_o}, 33'h2); // Own pull.
    rd(A_ST2, 8'h70); // Both overtemp flags.
    tick('0);
    rd(A_ST2, 8'h20); // Cleared, diode error stays.
    repeat (8) @(posedge core_clk);
    ext_pull <= 1'b1;
    repeat (10) @(posedge core_clk);
    ext_pull <= 1'b0;
    rd(A_ST2, 8'hA0); // Outside pull seen.
    rd(A_ST2, 8'h20); // Cleared by the read.
    wr(A_CFG1, 8'h90);
    #1 chk({32'h0, monitor_en}, 33'h0); // Monitoring off.
    m = '0;
    m.rem_high[0] = 1'b1;
    tick(m);
    rd(A_ST1, 8'h00); // No update while monitoring is off.
    wr(A_CFG1, 8'h91);
    wr(A_CFG2, 8'h15);
    tick(m);
    repeat (3) @(posedge core_clk);
    #1 chk({32'h0, alert}, 33'h0); // Remote 1 alert masked.
    repeat (8) begin
      #1 e2 = pwm_drive & 2'b01;
      @(posedge core_clk);
      #1 chk({31'h0, fan_pwm}, {31'h0, e2}); // Fan 2 drive held off.
      chk({32'h0, tach_out[1]}, 33'h0); // Fan 2 sense ignored.
    end
    rd(A_ST1, 8'h04); // Flag set though not alerted.
    tick('0);
    for (int i = 0; i < 8; i++) begin
      wr(A_FAN1, {i[1:0], i[2:0], i[2:0]});
      repeat (2) @(posedge core_clk);
      #1 chk({1'b0, fan1_cfg}, {1'b0, SP[i], FQ[i], DV[i[1:0]]}); // Codes.
    end
    wr(A_CFG2, 8'h80);
    #1 chk({32'h0, soft_reset}, 33'h1); // Soft reset pulse.
    repeat (2) @(posedge core_clk);
    rd(A_CFG2, 8'h3F); // Self-cleared, defaults back.
    rd(A_FAN1, 8'h5D); // Soft reset restores fan 1 defaults.
    rd(A_CFG1, 8'h90); // Soft reset restores config-1.
    rd(A_ST2, 8'h20); // Diode error kept.
    summarize();
  end

endmodule : fthcsr_regs_tb_top
